// ==== rtl/supervisor_pkg.sv ====
// constants, encodings and carrier types for the supply supervisor
package supervisor_pkg;

   // clock and time base
   localparam int CLOCK_HZ          = 20_000_000;
   localparam int RES_DELAY_MIN_MS  = 8;
   localparam int WINDOW_MIN_MS     = 16;
   localparam int WAKE_PULSE_US     = 50;
   localparam int RES_DELAY_MIN_CYC = RES_DELAY_MIN_MS * (CLOCK_HZ / 1000);
   localparam int WINDOW_MIN_CYC    = WINDOW_MIN_MS * (CLOCK_HZ / 1000);
   localparam int WAKE_CYC          = (WAKE_PULSE_US * (CLOCK_HZ / 1000) + 999) / 1000;
   localparam int CNT_W             = 23;
   localparam int WAKE_W            = 11;

   // control word layout
   localparam int WORD_W         = 16;
   localparam int CTL_WDG_DIS_A  = 0;
   localparam int CTL_TRK_LSB    = 2;
   localparam int TRK_N          = 6;
   localparam int CTL_SLEEP      = 8;
   localparam int CTL_WDG_DIS_B  = 9;
   localparam int CTL_RES_LSB    = 10;
   localparam int CTL_WIN_LSB    = 12;
   localparam int CTL_WDG_DIS_C  = 14;
   localparam int CTL_KICK       = 15;
   localparam logic [15:0] CTRL_DEFAULT   = 16'h4301;
   localparam logic [2:0]  WDG_OFF_CODE   = 3'h2;
   localparam logic [1:0]  MAX_SCALE      = 2'h3;

   // status word layout
   localparam int ST_ERR       = 0;
   localparam int ST_TEMP      = 1;
   localparam int ST_TRK_LSB   = 2;
   localparam int ST_RAMGOOD1  = 8;
   localparam int ST_RAMGOOD2  = 9;
   localparam int ST_CLOSED    = 10;
   localparam int ST_RST_LSB   = 11;
   localparam int ST_WDG_ERR   = 14;
   localparam int ST_DCDC      = 15;
   localparam logic [15:0] STATUS_DEFAULT = 16'h8000;

   localparam int RAIL_N = 3;

   typedef enum logic [1:0] {PWR_OFF, PWR_ON, PWR_HOT} pwr_e;
   typedef enum logic [1:0] {WDG_IDLE, WDG_CLOSED, WDG_OPEN, WDG_FAIL} wdg_e;

   // asynchronous pin levels, synchronised as one bundle
   typedef struct packed {
      logic                csB;
      logic                wake;
      logic                tempShutdown;
      logic                tempWarn;
      logic                secondBelow1v4;
      logic                main5vBelow2v3;
      logic                main5vAbove3v3;
      logic [RAIL_N-1:0]   railOk;
      logic [RAIL_N-1:0]   resetPin;
      logic [TRK_N-1:0]    trackerSettled;
   } pins_s;

   localparam pins_s PINS_IDLE = '{csB: 1'b1, default: '0};

endpackage

// ==== rtl/spi_link.sv ====
// serial shifter on the master's clock: control word in, status word out
`timescale 1ns/100ps
module spi_link
   import supervisor_pkg::*;
(
   input  wire logic              spiClock,
   input  wire logic              chipSelectB,
   input  wire logic              rstSyncB,
   input  wire logic              serialIn,
   input  wire logic [WORD_W-1:0] statusWord,
   output logic      [WORD_W-1:0] rxWord,
   output logic                   serialOut,
   output logic                   serialOutOe
);

   logic [4:0] bitCount;

   // bit counter lives only while chip select is low
   always_ff @(posedge spiClock or posedge chipSelectB)
   begin
      if (chipSelectB)
         bitCount <= 5'h00;
      else if (!bitCount[4])
         bitCount <= bitCount + 5'h01;
   end

   // last sixteen bits stay put after the frame for the other domain to fetch
   always_ff @(posedge spiClock or negedge rstSyncB)
   begin
      if (!rstSyncB)
         rxWord <= 16'h0000;
      else if (!chipSelectB)
         rxWord <= {rxWord[WORD_W-2:0], serialIn}; // R20
   end

   // status first, then the bits taken in sixteen clocks earlier for chaining
   always_comb
   begin
      serialOut   = bitCount[4] ? rxWord[WORD_W-1] : statusWord[4'hF - bitCount[3:0]]; // R20
      serialOutOe = ~chipSelectB; // R21
   end

endmodule

// ==== rtl/spi_supervisor_window_watchdog.sv ====
// supervisor: reset delays, start-up and sleep, window watchdog, status and error pin
// What this block and its host must do
// R1: each rail's reset stays low until delay elapses after rail is good
// R2: reset delay defaults to 64 ms, selectable down to 32, 16 or 8 ms
// R3: settings kept if main rail stayed above 3.3V, else defaults at power-up
// R4: on cold start control word held at defaults, commands ignored during delay
// R5: ram-good flags set when main below 2.3V or second rail below 1.4V
// R6: both ram-good flags cleared after each completed serial transfer
// R7: error pin driven low while any fault is present
// R8: watchdog kick counts only with kick bit set, at chip-select rising edge
// R9: host clears kick bit on status-only accesses
// R10: watchdog disabled only by disable bits holding 010
// R11: new window length sent with kick starts next closed window at once
// R12: host waits over 1/48 window between disable and enable
// R13: first closed window begins after the full main-rail reset delay
// R14: missing kick drives error low at once, reset after half closed window
// R15: premature kick handled exactly like a missing one
// R16: temperature warning sets error and flag; shutdown turns off until cleared
// R17: start on wake held high for at least 50 us
// R18: sleep bit zero turns regulators off only while wake is low
// R19: host writes sleep bit as one in every transfer
// R20: 16-bit word in, status out in lockstep; chaining and byte masters work
// R21: frame opens on select falling; word applied, output released on rising
// R22: all delays and windows counted on the internal clock, scaled by setting
// R23: delay bits 00=64, 10=32, 01=16, 11=8 ms
// R24: window bits 00=128, 10=64, 01=32, 11=16 ms for both windows
// R25: each tracker bit switches its tracker, all off by default
// R26: any disable code but 010 keeps watchdog on, default 111
`timescale 1ns/100ps
module spi_supervisor_window_watchdog
   import supervisor_pkg::*;
#(
   parameter int RES_BASE_CYC = RES_DELAY_MIN_CYC,
   parameter int WIN_BASE_CYC = WINDOW_MIN_CYC
)
(
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic              spiClock,
   input  wire logic              chipSelectB,
   input  wire logic              serialIn,
   output logic                   serialOut,
   output logic                   serialOutOe,
   input  wire logic              main5vRailOk,
   input  wire logic              secondRailOk,
   input  wire logic              thirdRailOk,
   input  wire logic              main5vAbove3v3,
   input  wire logic              main5vBelow2v3,
   input  wire logic              secondBelow1v4,
   input  wire logic              tempWarn,
   input  wire logic              tempShutdown,
   input  wire logic              wake,
   input  wire logic [TRK_N-1:0]  trackerSettled,
   input  wire logic              resetOutMainRailIn,
   output logic                   resetOutMainRailOut,
   output logic                   resetOutMainRailOe,
   input  wire logic              resetOutSecondRailIn,
   output logic                   resetOutSecondRailOut,
   output logic                   resetOutSecondRailOe,
   input  wire logic              resetOutThirdRailIn,
   output logic                   resetOutThirdRailOut,
   output logic                   resetOutThirdRailOe,
   output logic                   regulatorsOn,
   output logic [TRK_N-1:0]       trackerEnableBits,
   output logic                   errorB
);

   typedef struct packed {
      pins_s                         meta;
      pins_s                         sync;
      logic                          csPrev;
      logic [WORD_W-1:0]             ctrl;
      logic                          coldPending;
      logic [RAIL_N-1:0][CNT_W-1:0]  railCnt;
      logic [RAIL_N-1:0]             railRelease;
      pwr_e                          pwr;
      logic [WAKE_W-1:0]             wakeCnt;
      wdg_e                          wdg;
      logic [CNT_W-1:0]              wdgCnt;
      logic                          ramGood1;
      logic                          ramGood2;
      logic                          errLatch;
      logic                          wdgErr;
      logic [WORD_W-1:0]             status;
      logic                          errorB;
      logic                          regOn;
      logic [TRK_N-1:0]              trackers;
   } state_s;

   localparam state_s STATE_RESET = '{
      meta:        PINS_IDLE,
      sync:        PINS_IDLE,
      csPrev:      1'b1,
      ctrl:        CTRL_DEFAULT,
      coldPending: 1'b1,
      pwr:         PWR_OFF,
      wdg:         WDG_IDLE,
      status:      STATUS_DEFAULT,
      errorB:      1'b1,
      default:     '0
   };

   logic [1:0]        rstPipe;
   logic              rstSyncB;
   state_s            s;
   state_s            next_s;
   pins_s             pinsIn;
   logic [WORD_W-1:0] rxWord;

   // reset release through two flops
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         rstPipe <= 2'h0;
      else
         rstPipe <= {rstPipe[0], 1'b1};
   end

   assign rstSyncB = rstPipe[1];

   always_comb
   begin
      pinsIn                = PINS_IDLE;
      pinsIn.csB            = chipSelectB;
      pinsIn.wake           = wake;
      pinsIn.tempShutdown   = tempShutdown;
      pinsIn.tempWarn       = tempWarn;
      pinsIn.secondBelow1v4 = secondBelow1v4;
      pinsIn.main5vBelow2v3 = main5vBelow2v3;
      pinsIn.main5vAbove3v3 = main5vAbove3v3;
      pinsIn.railOk         = {thirdRailOk, secondRailOk, main5vRailOk};
      pinsIn.resetPin       = {resetOutThirdRailIn, resetOutSecondRailIn, resetOutMainRailIn};
      pinsIn.trackerSettled = trackerSettled;
   end

   spi_link u_link (
      .spiClock    (spiClock),
      .chipSelectB (chipSelectB),
      .rstSyncB    (rstSyncB),
      .serialIn    (serialIn),
      .statusWord  (s.status),
      .rxWord      (rxWord),
      .serialOut   (serialOut),
      .serialOutOe (serialOutOe)
   );

   logic             frameEnd;
   logic             accept;
   logic             kick;
   logic             wdgEnabled;
   logic             wdgReset;
   logic [1:0]       resScale;
   logic [1:0]       winScale;
   logic [CNT_W-1:0] resDelay;
   logic [CNT_W-1:0] winLen;
   logic [CNT_W-1:0] halfWin;
   logic             enterFail;

   always_comb
   begin
      next_s      = s;
      next_s.meta = pinsIn;
      next_s.sync = s.meta;

      // select has settled high: the shifted word is stable and may be fetched
      frameEnd      = s.sync.csB & ~s.csPrev; // R21
      next_s.csPrev = s.sync.csB;
      accept        = frameEnd & ~s.coldPending & (s.pwr == PWR_ON); // R4
      kick          = accept & rxWord[CTL_KICK]; // R8

      // settings live on unless the main rail sagged below 3.3V
      if (!s.sync.main5vAbove3v3)
         next_s.coldPending = 1'b1; // R3
      else if (s.railRelease[0])
         next_s.coldPending = 1'b0; // R4

      if (s.coldPending)
         next_s.ctrl = CTRL_DEFAULT; // R4
      else if (accept)
         next_s.ctrl = rxWord; // R21

      resScale = MAX_SCALE - {s.ctrl[CTL_RES_LSB+1], s.ctrl[CTL_RES_LSB]}; // R23
      winScale = MAX_SCALE - {s.ctrl[CTL_WIN_LSB+1], s.ctrl[CTL_WIN_LSB]}; // R24
      resDelay = CNT_W'(RES_BASE_CYC) << resScale; // R2
      winLen   = CNT_W'(WIN_BASE_CYC) << winScale; // R22
      halfWin  = winLen >> 1;

      wdgEnabled = {s.ctrl[CTL_WDG_DIS_A], s.ctrl[CTL_WDG_DIS_B], s.ctrl[CTL_WDG_DIS_C]}
                   != WDG_OFF_CODE; // R10 R26

      // power state: wake start, sleep command, thermal shutdown
      case (s.pwr)
         PWR_OFF:
         begin
            if (s.sync.tempShutdown)
               next_s.wakeCnt = '0;
            else if (s.sync.wake)
            begin
               if (s.wakeCnt >= WAKE_W'(WAKE_CYC - 1))
               begin
                  next_s.pwr            = PWR_ON; // R17
                  next_s.wakeCnt        = '0;
                  next_s.ctrl[CTL_SLEEP] = 1'b1;
               end
               else
                  next_s.wakeCnt = s.wakeCnt + WAKE_W'(1);
            end
            else
               next_s.wakeCnt = '0;
         end
         PWR_ON:
         begin
            if (s.sync.tempShutdown)
               next_s.pwr = PWR_HOT; // R16
            else if (!s.ctrl[CTL_SLEEP] && !s.sync.wake)
               next_s.pwr = PWR_OFF; // R18
         end
         PWR_HOT:
         begin
            if (!s.sync.tempShutdown)
               next_s.pwr = PWR_ON; // R16
         end
         default:
            next_s.pwr = PWR_OFF;
      endcase
      next_s.regOn    = (next_s.pwr == PWR_ON);
      next_s.trackers = s.ctrl[CTL_TRK_LSB +: TRK_N] & {TRK_N{s.regOn}}; // R25

      // window watchdog
      wdgReset  = 1'b0;
      enterFail = 1'b0;
      case (s.wdg)
         WDG_IDLE:
         begin
            next_s.wdgCnt = '0;
            if (wdgEnabled && s.railRelease[0])
               next_s.wdg = WDG_CLOSED; // R13
         end
         WDG_CLOSED:
         begin
            if (kick)
            begin
               next_s.wdg    = WDG_FAIL; // R15
               next_s.wdgCnt = '0;
               enterFail     = 1'b1;
            end
            else if (s.wdgCnt >= winLen - CNT_W'(1))
            begin
               next_s.wdg    = WDG_OPEN;
               next_s.wdgCnt = '0;
            end
            else
               next_s.wdgCnt = s.wdgCnt + CNT_W'(1);
         end
         WDG_OPEN:
         begin
            if (kick)
            begin
               next_s.wdg    = WDG_CLOSED; // R11
               next_s.wdgCnt = '0;
            end
            else if (s.wdgCnt >= winLen - CNT_W'(1))
            begin
               next_s.wdg    = WDG_FAIL; // R14
               next_s.wdgCnt = '0;
               enterFail     = 1'b1;
            end
            else
               next_s.wdgCnt = s.wdgCnt + CNT_W'(1);
         end
         WDG_FAIL:
         begin
            if (s.wdgCnt >= halfWin - CNT_W'(1))
            begin
               wdgReset      = 1'b1; // R14 R15
               next_s.wdg    = WDG_IDLE;
               next_s.wdgCnt = '0;
            end
            else
               next_s.wdgCnt = s.wdgCnt + CNT_W'(1);
         end
         default:
         begin
            next_s.wdg    = WDG_IDLE;
            next_s.wdgCnt = '0;
         end
      endcase
      // a disabled or held watchdog parks with cleared counters unless it is in fail
      if ((!wdgEnabled || !s.railRelease[0]) && s.wdg != WDG_FAIL)
      begin
         next_s.wdg    = WDG_IDLE; // R10
         next_s.wdgCnt = '0;
         enterFail     = 1'b0;
      end

      // per-rail reset delay
      for (int i = 0; i < RAIL_N; i++)
      begin
         if (!s.sync.railOk[i] || !s.regOn || wdgReset)
         begin
            next_s.railCnt[i]     = '0; // R1
            next_s.railRelease[i] = 1'b0;
         end
         else if (!s.railRelease[i])
         begin
            if (s.railCnt[i] >= resDelay - CNT_W'(1))
               next_s.railRelease[i] = 1'b1; // R1 R22
            else
               next_s.railCnt[i] = s.railCnt[i] + CNT_W'(1);
         end
      end

      // sticky flags: a new event beats the clear at frame end
      if (frameEnd)
      begin
         next_s.ramGood1 = 1'b0; // R6
         next_s.ramGood2 = 1'b0; // R6
         next_s.errLatch = 1'b0;
         next_s.wdgErr   = 1'b0;
      end
      if (s.sync.main5vBelow2v3)
         next_s.ramGood1 = 1'b1; // R5
      if (s.sync.secondBelow1v4)
         next_s.ramGood2 = 1'b1; // R5
      if (enterFail)
         next_s.wdgErr = 1'b1;
      if (s.sync.tempWarn || enterFail || s.sync.main5vBelow2v3 || s.sync.secondBelow1v4)
         next_s.errLatch = 1'b1; // R16

      next_s.errorB = ~(next_s.errLatch | s.sync.tempWarn | (next_s.wdg == WDG_FAIL)); // R7

      // status frozen while a frame runs
      if (s.sync.csB)
      begin
         next_s.status[ST_ERR]                 = s.errLatch;
         next_s.status[ST_TEMP]                = s.sync.tempWarn; // R16
         next_s.status[ST_TRK_LSB +: TRK_N]    = s.sync.trackerSettled & s.trackers;
         next_s.status[ST_RAMGOOD1]            = s.ramGood1;
         next_s.status[ST_RAMGOOD2]            = s.ramGood2;
         next_s.status[ST_CLOSED]              = (s.wdg == WDG_CLOSED);
         next_s.status[ST_RST_LSB +: RAIL_N]   = ~s.sync.resetPin;
         next_s.status[ST_WDG_ERR]             = s.wdgErr;
         next_s.status[ST_DCDC]                = s.regOn;
      end
   end

   always_ff @(posedge clock or negedge rstSyncB)
   begin
      if (!rstSyncB)
         s <= STATE_RESET;
      else
         s <= next_s;
   end

   // reset pins are open drain: drive low while held
   assign resetOutMainRailOut   = 1'b0;
   assign resetOutSecondRailOut = 1'b0;
   assign resetOutThirdRailOut  = 1'b0;
   assign resetOutMainRailOe    = ~s.railRelease[0];
   assign resetOutSecondRailOe  = ~s.railRelease[1];
   assign resetOutThirdRailOe   = ~s.railRelease[2];
   assign regulatorsOn          = s.regOn;
   assign trackerEnableBits     = s.trackers;
   assign errorB                = s.errorB;

endmodule

// ==== dv/spi_host_model.sv ====
// microcontroller side of the serial link: frames a word and collects status
`timescale 1ns/100ps
module spi_host_model
(
   output logic      spiClock,
   output logic      chipSelectB,
   output logic      serialIn,
   input  wire logic serialOut,
   input  wire logic serialOutOe
);
   initial
   begin
      spiClock    = 1'b0;
      chipSelectB = 1'b1;
      serialIn    = 1'b0;
   end

   // one frame; the clock stands low outside it, data shows the inverse once done
   task automatic xfer(input logic [15:0] word, output logic [15:0] status);
      logic [15:0] sh;
      sh          = word;
      chipSelectB = 1'b0;
      serialIn    = sh[15];
      for (int i = 15; i >= 0; i--)
      begin
         #24;
         status[i] = serialOutOe ? serialOut : 1'bx;
         spiClock  = 1'b1;
         #24;
         spiClock  = 1'b0;
         sh        = {sh[14:0], ~sh[0]};
         serialIn  = sh[15];
      end
      #24;
      chipSelectB = 1'b1;
      #250;
   endtask
endmodule

// ==== dv/spi_supervisor_window_watchdog_assertions.sv ====
// concurrent checks on the supervisor's pins
`timescale 1ns/100ps
module spi_supervisor_window_watchdog_assertions
   import supervisor_pkg::*;
#(
   parameter int RES_BASE_CYC = RES_DELAY_MIN_CYC
)
(
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic             chipSelectB,
   input  wire logic             serialOutOe,
   input  wire logic             main5vRailOk,
   input  wire logic             secondRailOk,
   input  wire logic             main5vBelow2v3,
   input  wire logic             tempWarn,
   input  wire logic             tempShutdown,
   input  wire logic             wake,
   input  wire logic             resetOutMainRailOut,
   input  wire logic             resetOutMainRailOe,
   input  wire logic             resetOutSecondRailOe,
   input  wire logic             regulatorsOn,
   input  wire logic [TRK_N-1:0] trackerEnableBits,
   input  wire logic             errorB
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   AST_OE_FOLLOWS_SELECT: assert property (serialOutOe == !chipSelectB)
      else $error("data output enable not tracking select");
   AST_PIN_PULLS_LOW_ONLY: assert property (resetOutMainRailOut == 1'b0)
      else $error("reset pin driven high");
   AST_MAIN_DROP_RESETS: assert property ($fell(main5vRailOk) |-> ##[1:6] resetOutMainRailOe)
      else $error("main reset not asserted after rail loss");
   AST_MAIN_DELAY_MIN: assert property ($fell(resetOutMainRailOe) |-> $past(main5vRailOk, RES_BASE_CYC))
      else $error("main reset released too early");
   AST_SECOND_DELAY_MIN: assert property ($fell(resetOutSecondRailOe) |-> $past(secondRailOk, RES_BASE_CYC))
      else $error("second reset released too early");
   AST_TRK_OFF_WHEN_DOWN: assert property (!regulatorsOn |=> trackerEnableBits == '0)
      else $error("tracker enabled while regulators off");
   AST_WARN_PULLS_ERR: assert property (tempWarn [*6] |-> !errorB)
      else $error("error pin high during temperature warning");
   AST_HOT_SHUTS_OFF: assert property (tempShutdown [*8] |=> !regulatorsOn)
      else $error("regulators on during thermal shutdown");
   AST_SLEEP_NEEDS_WAKE_LOW: assert property ($fell(regulatorsOn) |-> !$past(wake, 3)
      || $past(tempShutdown, 3) || $past(tempShutdown, 4))
      else $error("regulators switched off with wake high");
   AST_RAMGOOD_ERR: assert property ($rose(main5vBelow2v3) |-> ##[2:8] !errorB)
      else $error("error pin not low after brown-out");
endmodule

bind spi_supervisor_window_watchdog spi_supervisor_window_watchdog_assertions
   #(.RES_BASE_CYC(RES_BASE_CYC)) u_chk
(
   .clock(clock), .rst_b(rst_b), .chipSelectB(chipSelectB), .serialOutOe(serialOutOe),
   .main5vRailOk(main5vRailOk), .secondRailOk(secondRailOk),
   .main5vBelow2v3(main5vBelow2v3), .tempWarn(tempWarn), .tempShutdown(tempShutdown),
   .wake(wake), .resetOutMainRailOut(resetOutMainRailOut),
   .resetOutMainRailOe(resetOutMainRailOe), .resetOutSecondRailOe(resetOutSecondRailOe),
   .regulatorsOn(regulatorsOn), .trackerEnableBits(trackerEnableBits), .errorB(errorB)
);

// ==== dv/spi_supervisor_window_watchdog_tb.sv ====
// self-checking bench for the supervisor
`timescale 1ns/100ps
module spi_supervisor_window_watchdog_tb
   import supervisor_pkg::*;
;
   logic             clock, rst_b, spiClock, chipSelectB, serialIn, serialOut, serialOutOe;
   logic             mainOk, secondOk, thirdOk, above3v3, below2v3, below1v4;
   logic             tempWarn, tempShutdown, wake, regulatorsOn, errorB;
   wire  [2:0]       pinIn, pinOut, pinOe;
   logic [TRK_N-1:0] trackerEnableBits;
   logic [15:0]      st;
   int               n_errors, comparisons, cycles, n;

   // pull-ups on the wired reset pins
   assign pinIn = ~pinOe;

   spi_supervisor_window_watchdog #(.RES_BASE_CYC(40), .WIN_BASE_CYC(80)) u_dut
   (
      .clock(clock), .rst_b(rst_b), .spiClock(spiClock), .chipSelectB(chipSelectB),
      .serialIn(serialIn), .serialOut(serialOut), .serialOutOe(serialOutOe),
      .main5vRailOk(mainOk), .secondRailOk(secondOk), .thirdRailOk(thirdOk),
      .main5vAbove3v3(above3v3), .main5vBelow2v3(below2v3), .secondBelow1v4(below1v4),
      .tempWarn(tempWarn), .tempShutdown(tempShutdown), .wake(wake),
      .trackerSettled(trackerEnableBits),
      .resetOutMainRailIn(pinIn[0]), .resetOutMainRailOut(pinOut[0]),
      .resetOutMainRailOe(pinOe[0]), .resetOutSecondRailIn(pinIn[1]),
      .resetOutSecondRailOut(pinOut[1]), .resetOutSecondRailOe(pinOe[1]),
      .resetOutThirdRailIn(pinIn[2]), .resetOutThirdRailOut(pinOut[2]),
      .resetOutThirdRailOe(pinOe[2]), .regulatorsOn(regulatorsOn),
      .trackerEnableBits(trackerEnableBits), .errorB(errorB)
   );

   spi_host_model u_host
   (
      .spiClock(spiClock), .chipSelectB(chipSelectB), .serialIn(serialIn),
      .serialOut(serialOut), .serialOutOe(serialOutOe)
   );

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_errors++;
         stop_test;
      end
   end

   task automatic stop_test;
      if (n_errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic checkIn(input int got, input int lo, input int hi);
      comparisons++;
      if (got < lo || got > hi)
      begin
         n_errors++;
         $display("[FAIL] %0t count %h outside %h..%h", $time, got, lo, hi);
      end
   endtask

   function automatic logic pick(int k);
      return k == 0 ? pinOe[0] : (k == 1 ? errorB : regulatorsOn);
   endfunction

   task automatic waitFor(input int k, input logic lvl, input int lim);
      n = 0;
      while (pick(k) !== lvl && n < lim)
      begin
         @(negedge clock);
         n++;
      end
   endtask

   task automatic idle(input int c);
      repeat (c) @(negedge clock);
   endtask

   task automatic send(input logic [15:0] w);
      u_host.xfer(w, st);
      @(negedge clock);
   endtask

   task automatic t_startup;
      int t0;
      waitFor(2, 1'b1, 1100);
      checkIn(n, 995, 1010);
      {mainOk, secondOk, thirdOk} = 3'b111;
      t0 = cycles;
      send(16'h037C);
      waitFor(0, 1'b0, 400);
      checkIn(cycles - t0, 320, 330);
      check(16'(trackerEnableBits), 16'h0);
      send(16'h0354);
      idle(3);
      check(16'(trackerEnableBits), 16'h15);
   endtask

   task automatic t_delay;
      int t0;
      for (int c = 0; c < 4; c++)
      begin
         send(16'h0354 | (16'(c) << 10));
         mainOk = 1'b0;
         idle(10);
         mainOk = 1'b1;
         t0 = cycles;
         waitFor(0, 1'b0, 400);
         checkIn(cycles - t0, 40 << (3 - c), (40 << (3 - c)) + 6);
      end
      above3v3 = 1'b0;
      mainOk = 1'b0;
      idle(10);
      {above3v3, mainOk} = 2'b11;
      t0 = cycles;
      waitFor(0, 1'b0, 400);
      checkIn(cycles - t0, 320, 326);
      check(16'(trackerEnableBits), 16'h0);
      send(16'h0300);
   endtask

   task automatic t_wdg;
      int t0;
      idle(30);
      send(16'h7F01);
      t0 = cycles;
      waitFor(1, 1'b0, 300);
      checkIn(cycles - t0, 150, 166);
      t0 = cycles;
      waitFor(0, 1'b1, 100);
      checkIn(cycles - t0, 38, 44);
      waitFor(0, 1'b0, 200);
      idle(20);
      send(16'h7F01);
      check(st, 16'hC401);
      idle(60);
      send(16'hDF01);
      idle(80);
      check(16'(errorB), 16'h1);
      send(16'hDF01);
      waitFor(1, 1'b0, 10);
      checkIn(n, 0, 9);
      t0 = cycles;
      waitFor(0, 1'b1, 300);
      checkIn(cycles - t0, 157, 166);
      waitFor(0, 1'b0, 200);
      send(16'h0F00);
   endtask

   task automatic t_flags;
      {below2v3, below1v4} = 2'b11;
      idle(10);
      {below2v3, below1v4} = 2'b00;
      idle(5);
      send(16'h0F00);
      check(st & 16'h0300, 16'h0300);
      send(16'h0F00);
      check(st & 16'h0300, 16'h0000);
      tempWarn = 1'b1;
      idle(10);
      send(16'h0F00);
      check(st & 16'h8003, 16'h8003);
      check(16'(errorB), 16'h0);
      tempWarn = 1'b0;
      send(16'h0F00);
      idle(3);
      check(16'(errorB), 16'h1);
      tempShutdown = 1'b1;
      idle(15);
      check(16'(regulatorsOn), 16'h0);
      tempShutdown = 1'b0;
      waitFor(2, 1'b1, 20);
      checkIn(n, 1, 19);
      waitFor(0, 1'b0, 200);
   endtask

   task automatic t_sleep;
      send(16'h0E00);
      idle(30);
      check(16'(regulatorsOn), 16'h1);
      send(16'h0F00);
      wake = 1'b0;
      idle(10);
      send(16'h0E00);
      idle(10);
      check(16'(regulatorsOn), 16'h0);
      {mainOk, secondOk, thirdOk} = 3'b000;
      wake = 1'b1;
      idle(1010);
      wake = 1'b0;
      waitFor(2, 1'b1, 20);
      idle(5);
      check(16'(regulatorsOn), 16'h1);
      {mainOk, secondOk, thirdOk} = 3'b111;
      waitFor(0, 1'b0, 400);
      idle(10);
      check(16'(pinOe), 16'h0);
      check(16'(pinOut), 16'h0);
   endtask

   initial
   begin
      {rst_b, mainOk, secondOk, thirdOk, below2v3, below1v4} = '0;
      {above3v3, wake} = 2'b11;
      {tempWarn, tempShutdown} = 2'b00;
      n_errors = 0;
      comparisons = 0;
      repeat (4) @(negedge clock);
      rst_b = 1'b1;
      t_startup;
      t_delay;
      t_wdg;
      t_flags;
      t_sleep;
      stop_test;
   end
endmodule
